//--- rtl/sbr_cfg.svh
// constants for the sdram burst and row activation block
//
// Overview of operation
// RQ1 - bursts 1,2,4,8; full page sequential only
// RQ2 - controller ends full page with terminate
// RQ3 - burst stays inside aligned column group
// RQ4 - upper column bits pick group, low start
// RQ5 - full page wraps from last column
// RQ6 - one bit selects sequential or interleaved
// RQ7 - sequential adds step, interleaved xors step
// RQ8 - read latency two or three clocks
// RQ9 - drive after n+m-1, valid at n+m
// RQ10 - controller limits clock rate per latency
// RQ11 - controller programs operating mode zero
// RQ12 - single write bit makes writes one column
// RQ13 - controller avoids reserved field encodings
// RQ14 - controller activates row before access
// RQ15 - controller rounds activate delay up
// RQ16 - same bank activate needs precharge, interval
// RQ17 - other bank activate allowed, spaced apart
// RQ18 - latency in bits four to six
// RQ19 - configure only with all banks idle
// RQ20 - configuration held until reloaded
// RQ21 - column counter advances each clock
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH
`define SBR_BL_LSB 0
`define SBR_BL_MSB 2
`define SBR_ORDER_BIT 3
`define SBR_LAT_LSB 4
`define SBR_LAT_MSB 6
`define SBR_OPM_LO_BIT 7
`define SBR_OPM_HI_BIT 8
`define SBR_SWR_BIT 9
`define SBR_BL_1 3'h0
`define SBR_BL_2 3'h1
`define SBR_BL_4 3'h2
`define SBR_BL_8 3'h3
`define SBR_BL_PAGE 3'h7
`define SBR_LAT_2 3'h2
`define SBR_LAT_3 3'h3
`define SBR_CLK_PERIOD_NS 50
`define SBR_ACT_ACCESS_NS 20
`define SBR_SAME_BANK_NS 70
`define SBR_CROSS_BANK_NS 15
`define SBR_PRE_NS 20
`define SBR_CYC(ns) (((ns) + `SBR_CLK_PERIOD_NS - 1) / `SBR_CLK_PERIOD_NS)
`define SBR_ACT_ACCESS_CYC `SBR_CYC(`SBR_ACT_ACCESS_NS)
`define SBR_SAME_BANK_CYC `SBR_CYC(`SBR_SAME_BANK_NS)
`define SBR_CROSS_BANK_CYC `SBR_CYC(`SBR_CROSS_BANK_NS)
`define SBR_PRE_CYC `SBR_CYC(`SBR_PRE_NS)
`define SBR_CFG_DEFAULT 13'h0032
`define SBR_WB_CMD 4'h0
`define SBR_WB_ADDR 4'h4
`define SBR_WB_WDATA 4'h8
`define SBR_WB_RDATA 4'hC
`endif

//--- rtl/sbr_pkg.sv
// types for the sdram burst and row activation block
package sbr_pkg;
  typedef enum logic [2:0] {
    SBR_NOP, SBR_ACT, SBR_RD, SBR_WR, SBR_PRE, SBR_TERM, SBR_LOAD
  } sbr_cmd_t;
endpackage : sbr_pkg

//--- rtl/sbr_link_if.sv
// link between the memory controller and the sdram core
`timescale 1ns/10ps
interface sbr_link_if;
  import sbr_pkg::*;
  logic [2:0] cmd;
  logic [1:0] bank;
  logic [12:0] addr;
  logic [31:0] dq_wr;
  logic [31:0] dq_rd;
  logic dq_rd_oe;
  modport ctrl (output cmd, output bank, output addr, output dq_wr,
    input dq_rd, input dq_rd_oe);
  modport mem (input cmd, input bank, input addr, input dq_wr,
    output dq_rd, output dq_rd_oe);
endinterface : sbr_link_if

//--- rtl/sbr_mem.sv
// sdram core: configuration, burst column generation, read latency
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "sbr_cfg.svh"
module sbr_mem
  import sbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  sbr_link_if.mem link,
  output logic [7:0] cur_col,
  output logic [1:0] cur_bank,
  output logic col_valid,
  output logic col_write
);
  // ---------------------------------------------
  // configuration
  // ---------------------------------------------
  logic [12:0] cfg_reg;
  wire [2:0] burst_length_field = cfg_reg[`SBR_BL_MSB:`SBR_BL_LSB];
  // RQ6 order select bit
  wire burst_order_select = cfg_reg[`SBR_ORDER_BIT];
  // RQ18 latency field bits
  wire [2:0] read_latency_field = cfg_reg[`SBR_LAT_MSB:`SBR_LAT_LSB];
  wire single_write_select = cfg_reg[`SBR_SWR_BIT];
  wire [2:0] cmd = link.cmd;

  // group mask from burst length; 0xFF means whole page
  function automatic logic [7:0] grp_mask(input logic [2:0] bl);
    case (bl)
      `SBR_BL_1: grp_mask = 8'h00;
      `SBR_BL_2: grp_mask = 8'h01;
      `SBR_BL_4: grp_mask = 8'h03;
      `SBR_BL_8: grp_mask = 8'h07;
      default: grp_mask = 8'hFF;
    endcase
  endfunction : grp_mask

  // RQ20 held till reload
  // reset stands in for power-up; contents otherwise undefined
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cfg_reg <= `SBR_CFG_DEFAULT;
    else if (cmd == 3'(SBR_LOAD)) cfg_reg <= link.addr;
  end

  // ---------------------------------------------
  // burst column generator
  // ---------------------------------------------
  logic [7:0] base_reg, start_reg, step_reg, mask_reg;
  logic [7:0] base_next, start_next, step_next, mask_next;
  logic run_reg, run_next, page_reg, page_next, wr_reg, wr_next;
  logic [1:0] bank_reg, bank_next;
  wire is_rd = (cmd == 3'(SBR_RD));
  wire is_wr = (cmd == 3'(SBR_WR));
  // RQ12 single write column
  wire [7:0] new_mask = (is_wr && single_write_select) ? 8'h00
    : grp_mask(burst_length_field);
  // RQ1 page only sequential
  wire new_page = (new_mask == 8'hFF) && !(is_wr && single_write_select);
  // RQ7 add or xor step
  wire [7:0] offs = burst_order_select && !page_reg
    ? ((start_reg ^ step_reg) & mask_reg)
    : ((start_reg + step_reg) & mask_reg);
  // RQ3 stay in group
  wire [7:0] col_now = (base_reg & ~mask_reg) | offs;
  wire last_step = !page_reg && (step_reg == mask_reg);

  always_comb begin
    base_next = base_reg;
    start_next = start_reg;
    step_next = step_reg;
    mask_next = mask_reg;
    run_next = run_reg;
    page_next = page_reg;
    wr_next = wr_reg;
    bank_next = bank_reg;
    if (is_rd || is_wr) begin
      // RQ4 group and start bits
      base_next = link.addr[7:0];
      start_next = link.addr[7:0] & new_mask;
      step_next = 8'h00;
      mask_next = new_mask;
      page_next = new_page;
      run_next = 1'b1;
      wr_next = is_wr;
      bank_next = link.bank;
    end else if (cmd == 3'(SBR_TERM) || cmd == 3'(SBR_PRE)) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      // RQ21 advance each clock
      // RQ5 page wraps naturally
      step_next = 8'(step_reg + 8'h01);
      if (last_step) run_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      base_reg <= 8'h00;
      start_reg <= 8'h00;
      step_reg <= 8'h00;
      mask_reg <= 8'h00;
      run_reg <= 1'b0;
      page_reg <= 1'b0;
      wr_reg <= 1'b0;
      bank_reg <= 2'h0;
    end else begin
      base_reg <= base_next;
      start_reg <= start_next;
      step_reg <= step_next;
      mask_reg <= mask_next;
      run_reg <= run_next;
      page_reg <= page_next;
      wr_reg <= wr_next;
      bank_reg <= bank_next;
    end
  end

  // ---------------------------------------------
  // column outputs and read pipeline
  // ---------------------------------------------
  // data array stands in for a small page slice per bank
  logic [31:0] mem_arr [0:1023];
  wire [9:0] mem_idx = {bank_reg, col_now};
  wire rd_now = run_reg && !wr_reg;
  logic [1:0] rv_reg;
  logic [31:0] rd1_reg;
  logic [31:0] rd_out_reg;
  logic oe_reg;
  // RQ8 latency two or three
  wire lat3 = (read_latency_field == `SBR_LAT_3);

  always_ff @(posedge ref_clk) begin
    if (run_reg && wr_reg) mem_arr[mem_idx] <= link.dq_wr;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cur_col <= 8'h00;
      cur_bank <= 2'h0;
      col_valid <= 1'b0;
      col_write <= 1'b0;
      rv_reg <= 2'h0;
      rd1_reg <= 32'h0;
      rd_out_reg <= 32'h0;
      oe_reg <= 1'b0;
    end else begin
      cur_col <= col_now;
      cur_bank <= bank_reg;
      col_valid <= run_reg;
      col_write <= run_reg && wr_reg;
      // RQ9 drive then valid
      // first column read is taken one edge after command; one more
      // stage gives latency two, a second stage gives three
      rv_reg <= {rv_reg[0], rd_now};
      rd1_reg <= mem_arr[mem_idx];
      oe_reg <= lat3 ? rv_reg[0] : rd_now;
      rd_out_reg <= lat3 ? rd1_reg : mem_arr[mem_idx];
    end
  end

  assign link.dq_rd = rd_out_reg;
  assign link.dq_rd_oe = oe_reg;
endmodule : sbr_mem

//--- rtl/sbr_ctrl.sv
// memory controller end: wishbone command port driving the sdram link
`timescale 1ns/10ps
`include "sbr_cfg.svh"
module sbr_ctrl
  import sbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  sbr_link_if.ctrl link
);
  // ---------------------------------------------
  // wishbone decode
  // ---------------------------------------------
  logic [31:0] cmd_reg, wdata_reg, rdata_reg;
  logic busy_reg, refused_reg;
  logic [2:0] lcmd_reg;
  logic [1:0] lbank_reg;
  logic [12:0] laddr_reg;
  logic [31:0] ldq_reg;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_cmd = req && wb_we_i && (wb_adr_i == `SBR_WB_CMD) && wb_sel_i[0];
  wire [2:0] new_cmd = wb_dat_i[2:0];
  wire [1:0] new_bank = wb_dat_i[5:4];
  wire [12:0] new_addr = wb_dat_i[28:16];
  wire [31:0] status = {29'h0, refused_reg, busy_reg, 1'b0};

  // ---------------------------------------------
  // activation spacing per bank and between banks
  // ---------------------------------------------
  logic [3:0] same_cnt [0:3];
  logic [3:0] open_cnt [0:3];
  logic [3:0] open_row;
  logic [3:0] cross_cnt;
  // RQ14 open row first
  wire need_open = (new_cmd == 3'(SBR_RD) || new_cmd == 3'(SBR_WR))
    && (!open_row[new_bank] || open_cnt[new_bank] != 4'h0);
  // RQ16 precharged and spaced
  // RQ17 cross bank spacing
  wire bad_act = (new_cmd == 3'(SBR_ACT)) && (open_row[new_bank]
    || same_cnt[new_bank] != 4'h0 || cross_cnt != 4'h0);
  // RQ19 load only idle
  // RQ11 RQ13 caller supplies legal mode fields
  wire bad_load = (new_cmd == 3'(SBR_LOAD)) && (open_row != 4'h0);
  wire refuse = need_open || bad_act || bad_load;
  wire fire = wr_cmd && !refuse;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bank
      wire hit = fire && new_bank == 2'(g);
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          same_cnt[g] <= 4'h0;
          open_cnt[g] <= 4'h0;
          open_row[g] <= 1'b0;
        end else if (hit && new_cmd == 3'(SBR_ACT)) begin
          // RQ15 rounded up delays
          same_cnt[g] <= 4'(`SBR_SAME_BANK_CYC);
          open_cnt[g] <= 4'(`SBR_ACT_ACCESS_CYC);
          open_row[g] <= 1'b1;
        end else if (hit && new_cmd == 3'(SBR_PRE)) begin
          open_row[g] <= 1'b0;
          same_cnt[g] <= (same_cnt[g] > 4'(`SBR_PRE_CYC)) ? same_cnt[g]
            : 4'(`SBR_PRE_CYC);
        end else begin
          if (same_cnt[g] != 4'h0) same_cnt[g] <= 4'(same_cnt[g] - 4'h1);
          if (open_cnt[g] != 4'h0) open_cnt[g] <= 4'(open_cnt[g] - 4'h1);
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cross_cnt <= 4'h0;
    else if (fire && new_cmd == 3'(SBR_ACT))
      cross_cnt <= 4'(`SBR_CROSS_BANK_CYC);
    else if (cross_cnt != 4'h0) cross_cnt <= 4'(cross_cnt - 4'h1);
  end

  // ---------------------------------------------
  // bus answer and link drive
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      cmd_reg <= 32'h0;
      wdata_reg <= 32'h0;
      rdata_reg <= 32'h0;
      busy_reg <= 1'b0;
      refused_reg <= 1'b0;
      lcmd_reg <= 3'(SBR_NOP);
      lbank_reg <= 2'h0;
      laddr_reg <= 13'h0;
      ldq_reg <= 32'h0;
    end else begin
      wb_ack_o <= req;
      lcmd_reg <= fire ? new_cmd : 3'(SBR_NOP);
      lbank_reg <= fire ? new_bank : lbank_reg;
      laddr_reg <= fire ? new_addr : laddr_reg;
      ldq_reg <= wdata_reg;
      // latest read word captured while memory drives it
      if (link.dq_rd_oe) rdata_reg <= link.dq_rd;
      busy_reg <= open_row != 4'h0;
      if (wr_cmd) refused_reg <= refuse;
      if (wr_cmd) cmd_reg <= wb_dat_i;
      if (req && wb_we_i && wb_adr_i == `SBR_WB_WDATA) wdata_reg <= wb_dat_i;
      case (wb_adr_i)
        `SBR_WB_CMD: wb_dat_o <= status;
        `SBR_WB_ADDR: wb_dat_o <= cmd_reg;
        `SBR_WB_WDATA: wb_dat_o <= wdata_reg;
        `SBR_WB_RDATA: wb_dat_o <= rdata_reg;
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // RQ2 terminate ends page burst
  assign link.cmd = lcmd_reg;
  assign link.bank = lbank_reg;
  assign link.addr = laddr_reg;
  assign link.dq_wr = ldq_reg;
endmodule : sbr_ctrl

//--- bench/sbr_link_asserts.sv
// assertions on the controller to sdram link
`timescale 1ns/10ps
module sbr_link_asserts
  import sbr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [2:0] cmd,
  input wire logic [1:0] bank,
  input wire logic [12:0] addr,
  input wire logic [31:0] dq_wr,
  input wire logic [31:0] dq_rd,
  input wire logic dq_rd_oe
);
  // -------------
  // shadow state
  // -------------
  logic [2:0] bl_reg;
  logic [2:0] lat_reg;
  logic [3:0] open_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // reset load is burst four, latency three
      bl_reg <= 3'h2;
      lat_reg <= 3'h3;
      open_reg <= 4'h0;
    end else begin
      if (cmd == SBR_LOAD) begin
        bl_reg <= addr[2:0];
        lat_reg <= addr[6:4];
      end
      if (cmd == SBR_ACT)
        open_reg[bank] <= 1'b1;
      if (cmd == SBR_PRE)
        open_reg[bank] <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_rd(b, l);
    cmd == SBR_RD && bl_reg == b && lat_reg == l;
  endsequence
  sequence s_quiet;
    (cmd == SBR_NOP) [*4];
  endsequence
  property p_lat3;
    cmd == SBR_RD && lat_reg == 3'h3 |-> ##3 dq_rd_oe;
  endproperty
  a_lat3: assert property (p_lat3) else $error("read data late");
  // only from an idle bus, a running burst would mask the edge
  property p_lat2;
    cmd == SBR_RD && lat_reg == 3'h2 && !dq_rd_oe |-> ##1 !dq_rd_oe ##1 dq_rd_oe;
  endproperty
  a_lat2: assert property (p_lat2) else $error("latency two wrong");
  property p_len1;
    s_rd(3'h0, 3'h3) ##1 s_quiet |-> !dq_rd_oe;
  endproperty
  a_len1: assert property (p_len1) else $error("single burst long");
  property p_len4;
    s_rd(3'h2, 3'h3) |-> ##3 dq_rd_oe [*4] ##1 !dq_rd_oe;
  endproperty
  a_len4: assert property (p_len4) else $error("burst four wrong");
  property p_len8;
    s_rd(3'h3, 3'h2) |-> ##2 dq_rd_oe [*8] ##1 !dq_rd_oe;
  endproperty
  a_len8: assert property (p_len8) else $error("burst eight wrong");
  property p_page;
    s_rd(3'h7, 3'h3) |-> ##3 dq_rd_oe [*8];
  endproperty
  a_page: assert property (p_page) else $error("page burst stopped");
  property p_open;
    cmd == SBR_RD || cmd == SBR_WR |-> open_reg[bank];
  endproperty
  a_open: assert property (p_open) else $error("access to closed bank");
  property p_load;
    cmd == SBR_LOAD |-> open_reg == 4'h0 && addr[8:7] == 2'h0;
  endproperty
  a_load: assert property (p_load) else $error("load while busy");
endmodule : sbr_link_asserts

//--- bench/sdram_burst_mode_and_row_activation_bench.sv
// bench: controller and sdram core face to face over the link
`timescale 1ns/10ps
module sdram_burst_mode_and_row_activation_bench;
  import sbr_pkg::*;
  logic ref_clk, resetn, cyc, stb, we, ack, cv, cw;
  logic [3:0] adr, sel;
  logic [31:0] wd, rdat, q, lastw;
  logic [7:0] ccol;
  logic [1:0] cbank;
  int errors, checks, seed, k, bl_m, il_m, swr_m, ec;
  int expc [$];
  logic [31:0] mem_m [0:1][0:255];
  logic [31:0] expq [$];
  sbr_link_if link ();
  sbr_ctrl u_sbr_ctrl (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link.ctrl));
  sbr_mem u_sbr_mem (.ref_clk(ref_clk), .resetn(resetn), .link(link.mem),
    .cur_col(ccol), .cur_bank(cbank), .col_valid(cv), .col_write(cw));
  sbr_link_asserts u_sbr_link_asserts (.ref_clk(ref_clk), .resetn(resetn),
    .cmd(link.cmd), .bank(link.bank), .addr(link.addr), .dq_wr(link.dq_wr),
    .dq_rd(link.dq_rd), .dq_rd_oe(link.dq_rd_oe));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ---------------
  // tasks and model
  // ---------------
  task automatic chk(input string s, input logic [31:0] v, e);
    checks++;
    if (v !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 9);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    if (n >= 9) begin
      errors++;
      conclude();
    end
  endtask : wb
  task automatic cm(input sbr_cmd_t c, input int b, input int a);
    wb(1'b1, 4'h0, {3'h0, a[12:0], 10'h0, b[1:0], 1'b0, c});
  endtask : cm
  // bank 0 closed first, loading with a row open is not allowed
  // latency two allowed
  task automatic cfg(input int bl, input int il, input int sw, input int lat);
    cm(SBR_PRE, 0, 0);
    cm(SBR_LOAD, 0, sw * 512 + lat * 16 + il * 8 + bl);
    cm(SBR_ACT, 0, 0);
    bl_m = bl;
    il_m = il;
    swr_m = sw;
  endtask : cfg
  function automatic int col(input int s, input int i);
    int m;
    m = (bl_m == 7) ? 255 : (1 << bl_m) - 1;
    return (s & ~m) | ((il_m != 0 ? (s ^ i) : (s + i)) & m);
  endfunction : col
  // write data is held, so a burst puts one word in every column
  task automatic wr(input int b, input int c, input logic [31:0] d);
    wb(1'b1, 4'h8, d);
    cm(SBR_WR, b, c);
    for (int i = 0; i < (swr_m != 0 ? 1 : 1 << bl_m); i++) begin
      mem_m[b][col(c, i)] = d;
      expc.push_back(b * 256 + col(c, i));
    end
    // data must stand until the burst has taken its last word
    repeat (8) @(posedge ref_clk);
  endtask : wr
  task automatic rd(input int b, input int c, input int w);
    int n;
    for (int i = 0; i < w; i++)
      expq.push_back(mem_m[b][col(c, i)]);
    cm(SBR_RD, b, c);
    if (bl_m == 7)
      return;
    n = 0;
    while (expq.size() != 0 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 40) begin
      errors++;
      conclude();
    end
    repeat (2) @(posedge ref_clk);
  endtask : rd
  always @(posedge ref_clk) begin
    if (cw === 1'b1) begin
      if (expc.size() == 0) begin
        chk("spare column", 32'h1, 32'h0);
      end else begin
        ec = expc.pop_front();
        chk("write column", {22'h0, cbank, ccol}, ec);
        chk("column valid", {31'h0, cv}, 32'h1);
      end
    end
    if (link.dq_rd_oe === 1'b1) begin
      if (expq.size() == 0) begin
        chk("spare word", 32'h1, 32'h0);
      end else begin
        lastw = expq.pop_front();
        chk("read word", link.dq_rd, lastw);
      end
    end
  end
  // ---------
  // sequence
  // ---------
  initial begin
    seed = 95;
    errors = 0;
    checks = 0;
    resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 4'h0;
    wd = 32'h0;
    // reset configuration is burst four
    bl_m = 2;
    il_m = 0;
    swr_m = 0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    wb(1'b0, 4'h0, 32'h0);
    chk("reset status", q, 32'h0);
    cm(SBR_ACT, 0, 0);
    cm(SBR_ACT, 1, 0);
    wb(1'b0, 4'h0, 32'h0);
    chk("row open", q & 32'h2, 32'h2);
    cm(SBR_ACT, 0, 0);
    wb(1'b0, 4'h0, 32'h0);
    chk("act refused", q & 32'h4, 32'h4);
    cm(SBR_RD, 2, 0);
    wb(1'b0, 4'h0, 32'h0);
    chk("closed bank", q & 32'h4, 32'h4);
    for (k = 0; k < 24; k++)
      wr(0, k < 16 ? k : k + 232, $random(seed));
    for (k = 0; k < 4; k++)
      wr(1, k, $random(seed));
    rd(1, 2, 4);
    cm(SBR_PRE, 1, 0);
    $display("test bank fill done");
    for (k = 0; k < 16; k++) begin
      cfg(k % 4, k / 4 % 2, 0, k < 8 ? 2 : 3);
      rd(0, $random(seed) & 15, 1 << (k % 4));
    end
    wb(1'b0, 4'hC, 32'h0);
    chk("last read", q, lastw);
    wb(1'b0, 4'h2, 32'h0);
    $display("test burst orders done");
    cfg(2, 0, 1, 3);
    wr(0, 5, $random(seed));
    cfg(2, 0, 0, 3);
    wr(0, 9, $random(seed));
    cfg(3, 1, 0, 3);
    rd(0, 8, 8);
    rd(0, 3, 8);
    $display("test write mode done");
    cfg(7, 0, 0, 3);
    rd(0, 252, 20);
    repeat (8) @(posedge ref_clk);
    cm(SBR_TERM, 0, 0);
    repeat (8) @(posedge ref_clk);
    chk("page words", 32'(expq.size() <= 12), 32'h1);
    expq.delete();
    cm(SBR_PRE, 0, 0);
    wb(1'b0, 4'h0, 32'h0);
    chk("rows closed", q & 32'h6, 32'h0);
    $display("test page done");
    conclude();
  end
endmodule : sdram_burst_mode_and_row_activation_bench
